// file: logic/nvsr_cfg.svh
// constants for the nonvolatile sram host controller
`ifndef NVSR_CFG_SVH
`define NVSR_CFG_SVH
`define NVSR_AW 13
`define NVSR_DW 8
`define NVSR_SEQ_A0 13'h0000
`define NVSR_SEQ_A1 13'h1555
`define NVSR_SEQ_A2 13'h0aaa
`define NVSR_SEQ_A3 13'h1fff
`define NVSR_SEQ_A4 13'h10f0
`define NVSR_SEQ_SAVE 13'h0f0f
`define NVSR_SEQ_RESTORE 13'h0f0e
`define NVSR_CLK_PS 4000
`define NVSR_SAVE_MS 10
`define NVSR_RESTORE_US 20
`define NVSR_PWRUP_US 550
// save time worked in nanoseconds over nanoseconds so the product stays inside 32-bit integer range
`define NVSR_SAVE_CYC (`NVSR_SAVE_MS * 1000000 / (`NVSR_CLK_PS / 1000))
`define NVSR_RESTORE_CYC (`NVSR_RESTORE_US * 1000000 / `NVSR_CLK_PS)
`define NVSR_PWRUP_CYC (`NVSR_PWRUP_US * 1000000 / `NVSR_CLK_PS)
`define NVSR_STROBE_CYC 5
`define NVSR_WAIT_W 24
`endif

// file: logic/nvsr_pkg.sv
// types for the nonvolatile sram host controller
package nvsr_pkg;
  typedef enum logic [2:0] {
    NVSR_IDLE = 3'b000,
    NVSR_SETUP = 3'b001,
    NVSR_STROBE = 3'b010,
    NVSR_HOLD = 3'b011,
    NVSR_WAIT = 3'b100
  } nvsr_state_t;
  typedef enum logic [1:0] {
    NVSR_CMD_READ = 2'b00,
    NVSR_CMD_WRITE = 2'b01,
    NVSR_CMD_SAVE = 2'b10,
    NVSR_CMD_RESTORE = 2'b11
  } nvsr_cmd_t;
endpackage

// file: logic/nvsr_timer.sv
// down counter that times strobes and nonvolatile waits
`timescale 1ns/100ps
`include "nvsr_cfg.svh"
module nvsr_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // load and status
  input wire logic load_i,
  input wire logic [`NVSR_WAIT_W-1:0] count_i,
  output logic done_o
);
  // ==========================================
  // counter
  logic [`NVSR_WAIT_W-1:0] cnt_reg; // cycles left
  logic [`NVSR_WAIT_W-1:0] cnt_next;
  // load wins over counting
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = count_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // done only once the count runs out and no reload is pending
  assign done_o = (cnt_reg == '0) && !load_i;
endmodule

// file: logic/nvsr_host.sv
// host controller driving an 8k x 8 nonvolatile sram through its pins
`timescale 1ns/100ps
`include "nvsr_cfg.svh"
// Contract
// - host holds address stable through write
// - host never writes at power-up restore end
// - save after six select reads, fixed order
// - restore: same five, then 0f0e
// - only reads advance; enable optional
// - power configuration fixed while running
// - write strobe high on all sequence reads
module nvsr_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // user command port
  input wire logic cmd_valid_i,
  input wire nvsr_pkg::nvsr_cmd_t cmd_i,
  input wire logic [`NVSR_AW-1:0] cmd_addr_i,
  input wire logic [`NVSR_DW-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [`NVSR_DW-1:0] rsp_rdata_o,
  // device pins
  output logic chip_sel_n_o,
  output logic write_n_o,
  output logic out_en_n_o,
  output logic [`NVSR_AW-1:0] address_lines_o,
  output logic [`NVSR_DW-1:0] data_lines_o,
  output logic data_lines_oe_n_o,
  input wire logic [`NVSR_DW-1:0] data_lines_i,
  input wire logic hw_save_busy_n_i
);
  // ==========================================
  // sequence lookup
  // address of step k of a save or restore trigger
  function automatic logic [`NVSR_AW-1:0] seq_addr(input logic [2:0] k, input logic restore);
    case (k)
      3'h0: seq_addr = `NVSR_SEQ_A0;
      3'h1: seq_addr = `NVSR_SEQ_A1;
      3'h2: seq_addr = `NVSR_SEQ_A2;
      3'h3: seq_addr = `NVSR_SEQ_A3;
      3'h4: seq_addr = `NVSR_SEQ_A4;
      default: seq_addr = restore ? `NVSR_SEQ_RESTORE : `NVSR_SEQ_SAVE;
    endcase
  endfunction

  // ==========================================
  // state
  nvsr_pkg::nvsr_state_t st_reg, st_next; // pin cycle phase
  nvsr_pkg::nvsr_cmd_t op_reg, op_next; // operation in flight
  logic [2:0] step_reg, step_next; // sequence read index
  logic [`NVSR_AW-1:0] addr_reg, addr_next;
  logic [`NVSR_DW-1:0] wdat_reg, wdat_next;
  logic ce_n_reg, ce_n_next;
  logic we_n_reg, we_n_next;
  logic oe_n_reg, oe_n_next;
  logic doe_n_reg, doe_n_next; // low while we drive data
  logic rdy_reg, rdy_next;
  logic rv_reg, rv_next;
  logic [`NVSR_DW-1:0] rd_reg, rd_next;
  logic pwr_reg, pwr_next; // power-up restore wait pending
  // timer interface
  logic tload;
  logic [`NVSR_WAIT_W-1:0] tcount;
  logic tdone;

  nvsr_timer u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tload),
    .count_i(tcount),
    .done_o(tdone)
  );

  // ==========================================
  // next-state logic
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    ce_n_next = ce_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    doe_n_next = doe_n_reg;
    rdy_next = rdy_reg;
    rv_next = 1'b0;
    rd_next = rd_reg;
    pwr_next = pwr_reg;
    tload = 1'b0;
    tcount = '0;
    case (st_reg)
      nvsr_pkg::NVSR_IDLE: begin
        // a busy device refuses all access, so hold off
        if (pwr_reg) begin
          // wait out power-up restore with write idle
          tload = 1'b1;
          tcount = `NVSR_WAIT_W'(`NVSR_PWRUP_CYC);
          // armed once per reset: the power configuration is taken as fixed while running
          pwr_next = 1'b0;
          rdy_next = 1'b0;
          st_next = nvsr_pkg::NVSR_WAIT;
        end else if (cmd_valid_i && rdy_reg && hw_save_busy_n_i) begin
          rdy_next = 1'b0;
          op_next = cmd_i;
          step_next = 3'h0;
          wdat_next = cmd_wdata_i;
          // reads and writes use the user address; triggers use the sequence
          if (cmd_i == nvsr_pkg::NVSR_CMD_READ || cmd_i == nvsr_pkg::NVSR_CMD_WRITE) begin
            addr_next = cmd_addr_i;
          end else begin
            addr_next = seq_addr(3'h0, cmd_i == nvsr_pkg::NVSR_CMD_RESTORE);
          end
          st_next = nvsr_pkg::NVSR_SETUP;
        end
      end
      nvsr_pkg::NVSR_SETUP: begin
        // address has been stable a cycle; now assert the strobes
        ce_n_next = 1'b0;
        if (op_reg == nvsr_pkg::NVSR_CMD_WRITE) begin
          we_n_next = 1'b0;
          oe_n_next = 1'b1;
          doe_n_next = 1'b0;
        end else begin
          we_n_next = 1'b1;
          oe_n_next = 1'b0;
        end
        tload = 1'b1;
        tcount = `NVSR_WAIT_W'(`NVSR_STROBE_CYC);
        st_next = nvsr_pkg::NVSR_STROBE;
      end
      nvsr_pkg::NVSR_STROBE: begin
        if (tdone) begin
          // select rises first so every cycle is select controlled
          ce_n_next = 1'b1;
          rd_next = data_lines_i;
          st_next = nvsr_pkg::NVSR_HOLD;
        end
      end
      nvsr_pkg::NVSR_HOLD: begin
        // address and data held one cycle past the rising select
        we_n_next = 1'b1;
        oe_n_next = 1'b1;
        doe_n_next = 1'b1;
        if (op_reg == nvsr_pkg::NVSR_CMD_READ || op_reg == nvsr_pkg::NVSR_CMD_WRITE) begin
          rv_next = (op_reg == nvsr_pkg::NVSR_CMD_READ);
          rdy_next = 1'b1;
          st_next = nvsr_pkg::NVSR_IDLE;
        end else if (step_reg != 3'h5) begin
          // back to back sequence reads with nothing between
          step_next = step_reg + 3'h1;
          addr_next = seq_addr(step_reg + 3'h1, op_reg == nvsr_pkg::NVSR_CMD_RESTORE);
          st_next = nvsr_pkg::NVSR_SETUP;
        end else begin
          // device now busy; keep pins idle for the full duration
          tload = 1'b1;
          tcount = (op_reg == nvsr_pkg::NVSR_CMD_SAVE) ? `NVSR_WAIT_W'(`NVSR_SAVE_CYC)
                                                       : `NVSR_WAIT_W'(`NVSR_RESTORE_CYC);
          st_next = nvsr_pkg::NVSR_WAIT;
        end
      end
      nvsr_pkg::NVSR_WAIT: begin
        if (tdone) begin
          rdy_next = 1'b1;
          st_next = nvsr_pkg::NVSR_IDLE;
        end
      end
      default: begin
        st_next = nvsr_pkg::NVSR_IDLE;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= nvsr_pkg::NVSR_IDLE;
      op_reg <= nvsr_pkg::NVSR_CMD_READ;
      step_reg <= 3'h0;
      addr_reg <= '0;
      wdat_reg <= '0;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      doe_n_reg <= 1'b1;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= '0;
      pwr_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      doe_n_reg <= doe_n_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      pwr_reg <= pwr_next;
    end
  end

  // ==========================================
  // outputs, straight from flip-flops
  assign chip_sel_n_o = ce_n_reg;
  assign write_n_o = we_n_reg;
  assign out_en_n_o = oe_n_reg;
  assign address_lines_o = addr_reg;
  assign data_lines_o = wdat_reg;
  assign data_lines_oe_n_o = doe_n_reg;
  assign cmd_ready_o = rdy_reg;
  assign rsp_valid_o = rv_reg;
  assign rsp_rdata_o = rd_reg;

  // ==========================================
  // checks
  a_seq_write_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!ce_n_reg && op_reg inside {nvsr_pkg::NVSR_CMD_SAVE, nvsr_pkg::NVSR_CMD_RESTORE}) |-> we_n_reg)
    else $error("write strobe low during trigger read");
  a_write_addr_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!we_n_reg && $past(!we_n_reg)) |-> $stable(addr_reg))
    else $error("address moved during write");
  a_write_oe_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !we_n_reg |-> oe_n_reg)
    else $error("output enable low during write");
  a_read_strobes: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!ce_n_reg && op_reg == nvsr_pkg::NVSR_CMD_READ) |-> (!oe_n_reg && we_n_reg))
    else $error("read strobes wrong");
  a_sel_rises_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($rose(ce_n_reg) && op_reg == nvsr_pkg::NVSR_CMD_WRITE) |-> !we_n_reg)
    else $error("write not ended by select");
  a_seq_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($fell(ce_n_reg) && op_reg == nvsr_pkg::NVSR_CMD_SAVE && step_reg == 3'h5) |-> addr_reg == `NVSR_SEQ_SAVE)
    else $error("save trigger last address wrong");
  a_restore_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($fell(ce_n_reg) && op_reg == nvsr_pkg::NVSR_CMD_RESTORE && step_reg == 3'h5) |-> addr_reg == `NVSR_SEQ_RESTORE)
    else $error("restore trigger last address wrong");
  a_wait_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_reg == nvsr_pkg::NVSR_WAIT) |-> (ce_n_reg && we_n_reg && !rdy_reg))
    else $error("pins active during transfer");
endmodule

// file: tb/nvsr_dev_model.sv
// pin-level behavioural model of the 8k x 8 nonvolatile sram
`timescale 1ns/100ps
`include "nvsr_cfg.svh"
// ==========
// device model, timed by the bench clock only
module nvsr_dev_model #(
  parameter int PWRUP_CYC = 1000,
  parameter int RESTORE_CYC = 5000,
  // finishes well inside the host's full save wait, which the rules allow
  parameter int SAVE_CYC = 2000,
  // automatic save on supply loss; fixed for the whole run
  parameter bit AUTO_SAVE = 1'b1
) (
  // model timing clock
  input wire logic clk_i,
  // holdup supply below the switch level
  input wire logic holdup_low_i,
  // control pins, active low
  input wire logic chip_sel_n_i,
  input wire logic write_n_i,
  input wire logic out_en_n_i,
  // address and data
  input wire logic [12:0] address_lines_i,
  input wire logic [7:0] data_lines_i,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe_n_o,
  // busy line, pulled up when released
  output logic hw_save_busy_n_o
);
  localparam logic [12:0] SEQ_TAB [0:4] = '{`NVSR_SEQ_A0, `NVSR_SEQ_A1, `NVSR_SEQ_A2, `NVSR_SEQ_A3, `NVSR_SEQ_A4};
  logic [7:0] sram [0:8191]; // one byte per address
  logic [7:0] nv [0:8191]; // shadow array
  int busy_cnt; // cycles left of a transfer
  int seq; // sequence reads matched so far
  logic saving, wr_seen, cs_q;
  logic [7:0] last_q;
  // power-up: pending restore latched and run at once
  initial begin
    for (int i = 0; i < 8192; i++) begin
      nv[i] = i[7:0] ^ 8'h5a;
      sram[i] = nv[i];
    end
    busy_cnt = PWRUP_CYC;
    seq = 0;
    saving = 1'b0;
    wr_seen = 1'b0;
    cs_q = 1'b1;
    last_q = 8'h00;
  end
  // access ends at the select rise; a supply dip saves unless the inhibit setting is chosen
  always @(posedge clk_i) begin
    cs_q <= chip_sel_n_i;
    last_q <= data_lines_o;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1; // all inputs ignored
      wr_seen <= 1'b0;
      if (busy_cnt == 1) saving <= 1'b0;
    end else if (AUTO_SAVE && holdup_low_i) begin
      // supply loss: copy to the shadow array on held-up charge and go busy
      for (int i = 0; i < 8192; i++) nv[i] <= sram[i];
      busy_cnt <= SAVE_CYC;
      saving <= 1'b1;
      wr_seen <= 1'b0;
      seq <= 0;
    end else if (!chip_sel_n_i) begin
      if (!write_n_i) wr_seen <= 1'b1;
    end else if (!cs_q) begin
      wr_seen <= 1'b0;
      if (wr_seen) begin
        sram[address_lines_i] <= data_lines_i;
        seq <= 0;
      end else if (seq == 5 && address_lines_i == `NVSR_SEQ_SAVE) begin
        for (int i = 0; i < 8192; i++) nv[i] <= sram[i]; // erase and program in one step
        busy_cnt <= SAVE_CYC;
        saving <= 1'b1;
        seq <= 0;
      end else if (seq == 5 && address_lines_i == `NVSR_SEQ_RESTORE) begin
        for (int i = 0; i < 8192; i++) sram[i] <= nv[i]; // nv left untouched
        busy_cnt <= RESTORE_CYC;
        seq <= 0;
      end else if (seq < 5 && address_lines_i == SEQ_TAB[seq]) seq <= seq + 1;
      else seq <= (address_lines_i == `NVSR_SEQ_A0) ? 1 : 0;
    end
  end
  // read drive; released lines flip so stale data never passes
  always_comb begin
    hw_save_busy_n_o = !saving;
    data_lines_oe_n_o = !(!chip_sel_n_i && !out_en_n_i && write_n_i && busy_cnt == 0);
    data_lines_o = data_lines_oe_n_o ? ~last_q : sram[address_lines_i];
  end
endmodule

// file: tb/nvsr_host_tb.sv
// self-checking bench for the nonvolatile sram host controller
`timescale 1ns/100ps
`include "nvsr_cfg.svh"
// ==========
// bench top
module nvsr_host_tb;
  logic clk_i, sys_rst_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, hw_save_busy_n_i;
  nvsr_pkg::nvsr_cmd_t cmd_i;
  logic [12:0] cmd_addr_i, address_lines_o;
  logic [7:0] cmd_wdata_i, rsp_rdata_o, data_lines_o, data_lines_i, dev_q, rd;
  logic chip_sel_n_o, write_n_o, out_en_n_o, data_lines_oe_n_o, dev_oe_n;
  logic holdup_low; // supply dip seen by the device model
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int lat;
  // wire level: whoever enables wins, else the flipping pattern
  assign data_lines_i = !dev_oe_n ? dev_q : (!data_lines_oe_n_o ? data_lines_o : dev_q);
  nvsr_host u_nvsr_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o), .out_en_n_o(out_en_n_o),
    .address_lines_o(address_lines_o), .data_lines_o(data_lines_o), .data_lines_oe_n_o(data_lines_oe_n_o),
    .data_lines_i(data_lines_i), .hw_save_busy_n_i(hw_save_busy_n_i));
  nvsr_dev_model u_nvsr_dev_model (.clk_i(clk_i), .holdup_low_i(holdup_low), .chip_sel_n_i(chip_sel_n_o),
    .write_n_i(write_n_o),
    .out_en_n_i(out_en_n_o), .address_lines_i(address_lines_o), .data_lines_i(data_lines_i),
    .data_lines_o(dev_q), .data_lines_oe_n_o(dev_oe_n), .hw_save_busy_n_o(hw_save_busy_n_i));
  // ==========
  // clock and hang guard; ceiling covers the power-up wait, two restores and a supply-loss save
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 160000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========
  // shared helpers
  task automatic stop_test();
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  // hold the command until taken, then count edges until ready returns
  task automatic do_cmd(input nvsr_pkg::nvsr_cmd_t c, input logic [12:0] a, input logic [7:0] d, input int lim);
    rd = 8'hxx;
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    do @(posedge clk_i); while (!(cmd_ready_o === 1'b1 && hw_save_busy_n_i === 1'b1));
    cmd_valid_i <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
      if (rsp_valid_o === 1'b1) rd = rsp_rdata_o;
    end while (lat < lim && cmd_ready_o !== 1'b1);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    do_cmd(nvsr_pkg::NVSR_CMD_READ, a, 8'h00, 20);
    check("read latency", 9, lat);
    check("read data", exp, rd);
  endtask
  // ==========
  // scenarios
  task automatic t_powerup();
    repeat (2) @(posedge clk_i);
    check("ready after reset", 0, cmd_ready_o);
    check("select idle", 1, chip_sel_n_o);
    rd_chk(13'h0123, 8'h23 ^ 8'h5a);
  endtask
  task automatic t_rw();
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h1fff, 8'ha5, 20);
    check("write latency", 9, lat);
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0000, 8'h3c, 20);
    rd_chk(13'h1fff, 8'ha5);
    rd_chk(13'h0000, 8'h3c);
    rd_chk(13'h1ffe, 8'hfe ^ 8'h5a);
  endtask
  task automatic t_abort();
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0456, 8'h77, 20);
    rd_chk(`NVSR_SEQ_A0, 8'h3c);
    rd_chk(`NVSR_SEQ_A1, 8'h55 ^ 8'h5a);
    rd_chk(`NVSR_SEQ_A2, 8'haa ^ 8'h5a);
    // the write between steps three and four must cancel the restore
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0456, 8'h77, 20);
    rd_chk(`NVSR_SEQ_A3, 8'ha5);
    rd_chk(`NVSR_SEQ_A4, 8'hf0 ^ 8'h5a);
    rd_chk(`NVSR_SEQ_RESTORE, 8'h0e ^ 8'h5a);
    rd_chk(13'h0456, 8'h77);
  endtask
  task automatic t_restore();
    do_cmd(nvsr_pkg::NVSR_CMD_RESTORE, 13'h0000, 8'h00, 6000);
    rd_chk(13'h0456, 8'h56 ^ 8'h5a);
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0456, 8'h11, 20);
    do_cmd(nvsr_pkg::NVSR_CMD_RESTORE, 13'h0000, 8'h00, 6000);
    rd_chk(13'h0456, 8'h56 ^ 8'h5a);
  endtask
  // supply dip: device saves by itself, host holds off while the busy line is low
  task automatic t_autosave();
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0456, 8'h5e, 20);
    holdup_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    holdup_low <= 1'b0;
    check("busy line on supply loss", 0, hw_save_busy_n_i);
    check("autosaved byte", 8'h5e, u_nvsr_dev_model.nv[13'h0456]);
    rd_chk(13'h0456, 8'h5e);
  endtask
  task automatic t_save();
    do_cmd(nvsr_pkg::NVSR_CMD_WRITE, 13'h0456, 8'h3c, 20);
    do_cmd(nvsr_pkg::NVSR_CMD_SAVE, 13'h0000, 8'h00, 200);
    check("ready during save", 0, cmd_ready_o);
    check("select during save", 1, chip_sel_n_o);
    check("saved byte", 8'h3c, u_nvsr_dev_model.nv[13'h0456]);
  endtask
  // ==========
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = nvsr_pkg::NVSR_CMD_READ;
    cmd_addr_i = 13'h0000;
    cmd_wdata_i = 8'h00;
    holdup_low = 1'b0;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_powerup();
    t_rw();
    t_abort();
    t_restore();
    t_autosave();
    t_save();
    stop_test();
  end
endmodule
